// ---- include/isrc_cfg_if.sv ----
// Configuration bundle between the register slave and the route logic
`timescale 1ns/100ps
interface isrc_cfg_if;
    logic [1:0] dma_sel;
    logic [5:0] level_chan;
    logic [3:0] sense;
    modport regs  (output dma_sel, output level_chan, output sense);
    modport route (input dma_sel, input level_chan, input sense);
endinterface : isrc_cfg_if

// ---- include/isrc_pkg.sv ----
// Shared constants for the interrupt source routing slice
package isrc_pkg;
    localparam int          NUM_SRC        = 2;
    // Register byte offsets
    localparam logic [3:0]  CFG_OFS        = 4'h0;
    localparam logic [3:0]  STAT_OFS       = 4'h4;
    // Per-source field layout inside the config word, one byte per source
    localparam int          SRC_STRIDE     = 8;
    localparam int          LVL_POS        = 0;
    localparam int          DMA_POS        = 3;
    localparam int          SENSE_POS      = 4;
    // Reset values of the fields
    localparam logic [2:0]  LVL_RST        = 3'h0;
    localparam logic        DMA_RST        = 1'h0;
    localparam logic [1:0]  SENSE_RST      = 2'h0;
    // Field codes
    localparam logic [1:0]  SENSE_RISE     = 2'h3;
    localparam logic [2:0]  LVL_OFF        = 3'h0;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
    // Idle and response states of the write channel
    typedef enum logic [1:0] {ISRC_W_IDLE, ISRC_W_RESP} isrc_wst_e;
endpackage : isrc_pkg

// ---- rtl/isrc_route.sv ----
// Edge detection and routing of the two sources to CPU or DMA
`timescale 1ns/100ps
module isrc_route
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    isrc_cfg_if.route       cfg,
    input  wire logic [1:0] req_sync,
    output logic      [1:0] cpu_req_r,
    output logic      [5:0] cpu_level_r,
    output logic      [1:0] dma_req_r,
    output logic      [5:0] dma_chan_r
);
    logic [1:0] req_prev_r;
    logic [1:0] req_prev_nxt;
    logic [1:0] cpu_req_nxt;
    logic [5:0] cpu_level_nxt;
    logic [1:0] dma_req_nxt;
    logic [5:0] dma_chan_nxt;

    // Per source: rising edge, then steer by the trigger select bit
    always_comb
    begin
        req_prev_nxt  = req_sync;
        cpu_req_nxt   = '0;
        dma_req_nxt   = '0;
        cpu_level_nxt = cpu_level_r;
        dma_chan_nxt  = dma_chan_r;
        for (int i = 0; i < isrc_pkg::NUM_SRC; i++)
        begin
            // Only the rising-edge code arms detection
            if (req_sync[i] && !req_prev_r[i] &&
                cfg.sense[2*i +: 2] == isrc_pkg::SENSE_RISE)
            begin
                if (cfg.dma_sel[i])
                begin
                    dma_req_nxt[i]       = 1'b1;
                    dma_chan_nxt[3*i+:3] = cfg.level_chan[3*i +: 3];
                end
                else if (cfg.level_chan[3*i +: 3] != isrc_pkg::LVL_OFF)
                begin
                    // Level 000 masks the source entirely
                    cpu_req_nxt[i]        = 1'b1;
                    cpu_level_nxt[3*i+:3] = cfg.level_chan[3*i +: 3];
                end
            end
        end
    end

    // Registered outputs; all clear at reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            req_prev_r  <= '0;
            cpu_req_r   <= '0;
            cpu_level_r <= '0;
            dma_req_r   <= '0;
            dma_chan_r  <= '0;
        end
        else
        begin
            req_prev_r  <= req_prev_nxt;
            cpu_req_r   <= cpu_req_nxt;
            cpu_level_r <= cpu_level_nxt;
            dma_req_r   <= dma_req_nxt;
            dma_chan_r  <= dma_chan_nxt;
        end
    end

    // Edge only, never level: a held request fires once
    a_pulse_once: assert property (@(posedge aclk) disable iff (!aresetn)
        cpu_req_r[0] |=> !cpu_req_r[0])
        else $error("cpu request lasted more than one cycle");
    a_dma_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        dma_req_r[0] |-> $past(cfg.dma_sel[0]))
        else $error("dma trigger without select bit");
    a_cpu_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        cpu_req_r[1] |-> !$past(cfg.dma_sel[1])
                         && $past(cfg.level_chan[5:3]) != 3'h0)
        else $error("cpu request while routed or disabled");
    a_dma_chan: assert property (@(posedge aclk) disable iff (!aresetn)
        dma_req_r[1] |-> dma_chan_r[5:3] == $past(cfg.level_chan[5:3]))
        else $error("dma channel mismatch");
    a_sense_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        (cpu_req_r[0] || dma_req_r[0]) |-> $past(cfg.sense[1:0]) == 2'h3)
        else $error("request without rising-edge sensitivity");
    a_edge_cause: assert property (@(posedge aclk) disable iff (!aresetn)
        dma_req_r[0] |-> $past(req_sync[0]) && !$past(req_sync[0], 2))
        else $error("dma trigger without rising edge");
endmodule : isrc_route

// ---- rtl/isrc_top.sv ----
// Interrupt source 20/21 configuration with AXI4-Lite register access
//
// Functional notes
// - Trigger select 0 keeps a source off DMA, 1 makes it a DMA trigger.
// - With select 0 the 3-bit field is priority, 000 off and 001-111 levels.
// - With select 1 the same field picks DMA channel 0 to 7.
// - Sensitivity code 11 picks rising edge and detection is on rising edges.
// - Reset clears select, level/channel and sensitivity fields to zero.
`timescale 1ns/100ps
module isrc_top
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        src20_req,
    input  wire logic        src21_req,
    output logic [1:0]       cpu_req,
    output logic [5:0]       cpu_level,
    output logic [1:0]       dma_req,
    output logic [5:0]       dma_chan
);
    isrc_cfg_if cfg_bus ();

    logic [1:0]  sync1_r;
    logic [1:0]  sync2_r;
    logic [15:0] cfg_r;
    logic [15:0] cfg_nxt;
    logic [1:0]  seen_r;
    logic [1:0]  seen_nxt;
    logic        aw_got_r;
    logic        aw_got_nxt;
    logic        w_got_r;
    logic        w_got_nxt;
    logic [3:0]  awaddr_r;
    logic [3:0]  awaddr_nxt;
    logic [31:0] wdata_r;
    logic [31:0] wdata_nxt;
    logic [3:0]  wstrb_r;
    logic [3:0]  wstrb_nxt;
    logic        bvalid_nxt;
    logic [1:0]  bresp_nxt;
    logic        rvalid_nxt;
    logic [1:0]  rresp_nxt;
    logic [31:0] rdata_nxt;
    logic        awready_nxt;
    logic        wready_nxt;
    logic        arready_nxt;
    logic        do_write;

    // Pins are asynchronous: two flops before any logic
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= {src21_req, src20_req};
            sync2_r <= sync1_r;
        end
    end

    // Fields fan out per source from the config word
    for (genvar g = 0; g < isrc_pkg::NUM_SRC; g++)
    begin : g_fld
        localparam int B = g * isrc_pkg::SRC_STRIDE;
        assign cfg_bus.dma_sel[g]        = cfg_r[B + isrc_pkg::DMA_POS];
        assign cfg_bus.level_chan[3*g+:3] = cfg_r[B + isrc_pkg::LVL_POS +: 3];
        assign cfg_bus.sense[2*g+:2]     = cfg_r[B + isrc_pkg::SENSE_POS +: 2];
    end

    assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;

    // Write channel: address and data taken in either order
    always_comb
    begin
        aw_got_nxt  = aw_got_r;
        w_got_nxt   = w_got_r;
        awaddr_nxt  = awaddr_r;
        wdata_nxt   = wdata_r;
        wstrb_nxt   = wstrb_r;
        bvalid_nxt  = s_axi_bvalid;
        bresp_nxt   = s_axi_bresp;
        cfg_nxt     = cfg_r;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_got_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_got_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        if (do_write)
        begin
            aw_got_nxt = 1'b0;
            w_got_nxt  = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt  = isrc_pkg::RESP_OKAY;
            if (awaddr_r[3:2] == isrc_pkg::CFG_OFS[3:2])
            begin
                // Sensitivity is stored as written; bad codes simply
                // disarm detection rather than being rejected
                if (wstrb_r[0])
                    cfg_nxt[7:0] = wdata_r[7:0] & 8'h3f;
                if (wstrb_r[1])
                    cfg_nxt[15:8] = wdata_r[15:8] & 8'h3f;
            end
            else if (awaddr_r[3:2] != isrc_pkg::STAT_OFS[3:2])
                bresp_nxt = isrc_pkg::RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
            bvalid_nxt = 1'b0;
        awready_nxt = !aw_got_nxt && !bvalid_nxt;
        wready_nxt  = !w_got_nxt && !bvalid_nxt;
    end

    // Read channel plus sticky seen-edge flags cleared on read, set wins
    always_comb
    begin
        rvalid_nxt  = s_axi_rvalid;
        rresp_nxt   = s_axi_rresp;
        rdata_nxt   = s_axi_rdata;
        seen_nxt    = seen_r;
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = isrc_pkg::RESP_OKAY;
            rdata_nxt  = '0;
            case (s_axi_araddr[3:2])
                isrc_pkg::CFG_OFS[3:2]:
                    rdata_nxt = {16'h0000, cfg_r};
                isrc_pkg::STAT_OFS[3:2]:
                begin
                    rdata_nxt = {28'h0000000, seen_r, sync2_r};
                    seen_nxt  = '0;
                end
                default:
                    rresp_nxt = isrc_pkg::RESP_SLVERR;
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
            rvalid_nxt = 1'b0;
        seen_nxt    = seen_nxt | cpu_req | dma_req;
        arready_nxt = !rvalid_nxt;
    end

    // Register stage; all fields zero out of reset
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cfg_r         <= 16'h0000;
            seen_r        <= '0;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= '0;
            wdata_r       <= '0;
            wstrb_r       <= '0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= isrc_pkg::RESP_OKAY;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= isrc_pkg::RESP_OKAY;
            s_axi_rdata   <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
        end
        else
        begin
            cfg_r         <= cfg_nxt;
            seen_r        <= seen_nxt;
            aw_got_r      <= aw_got_nxt;
            w_got_r       <= w_got_nxt;
            awaddr_r      <= awaddr_nxt;
            wdata_r       <= wdata_nxt;
            wstrb_r       <= wstrb_nxt;
            s_axi_bvalid  <= bvalid_nxt;
            s_axi_bresp   <= bresp_nxt;
            s_axi_rvalid  <= rvalid_nxt;
            s_axi_rresp   <= rresp_nxt;
            s_axi_rdata   <= rdata_nxt;
            s_axi_awready <= awready_nxt;
            s_axi_wready  <= wready_nxt;
            s_axi_arready <= arready_nxt;
        end
    end

    isrc_route u_route
    (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .cfg         (cfg_bus.route),
        .req_sync    (sync2_r),
        .cpu_req_r   (cpu_req),
        .cpu_level_r (cpu_level),
        .dma_req_r   (dma_req),
        .dma_chan_r  (dma_chan)
    );

    a_reset_clear: assert property (@(posedge aclk)
        !aresetn |=> cfg_r == 16'h0000)
        else $error("config not cleared by reset");
    a_write_lands: assert property (@(posedge aclk) disable iff (!aresetn)
        do_write && awaddr_r[3:2] == 2'h0 && wstrb_r[0]
        |=> cfg_r[7:0] == ($past(wdata_r[7:0]) & 8'h3f))
        else $error("config write lost");
endmodule : isrc_top

// ---- tb/isrc_sink.sv ----
// Far-side model: CPU interrupt logic and DMA trigger receiver
`timescale 1ns/100ps
module isrc_sink
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [1:0] cpu_req,
    input  wire logic [5:0] cpu_level,
    input  wire logic [1:0] dma_req,
    input  wire logic [5:0] dma_chan,
    output logic            evt_r,
    output logic [7:0]      evt_word_r
);
    // Each cycle with a pulse becomes one event word: kind, source, level or channel; on a tie DMA wins, then source 1
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            evt_r      <= 1'b0;
            evt_word_r <= 8'h00;
        end
        else
        begin
            evt_r <= |{cpu_req, dma_req};
            if (|dma_req)
                evt_word_r <= {4'h1, dma_req[1], dma_req[1] ?
                    dma_chan[5:3] : dma_chan[2:0]};
            else
                evt_word_r <= {4'h0, cpu_req[1], cpu_req[1] ?
                    cpu_level[5:3] : cpu_level[2:0]};
        end
    end
endmodule // isrc_sink

// ---- tb/tb.sv ----
// Self-checking bench for the source routing block
`timescale 1ns/100ps
module tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [3:0]  s_axi_araddr = 4'h0;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic        src20_req = 1'b0;
    logic        src21_req = 1'b0;
    logic [1:0]  cpu_req;
    logic [5:0]  cpu_level;
    logic [1:0]  dma_req;
    logic [5:0]  dma_chan;
    logic        evt;
    logic [7:0]  evt_word;
    logic [7:0]  exp_q[$];
    logic [3:0]  strb_v = 4'h3;
    int          error_cnt = 0;
    int          total_checks = 0;

    // System clock, 8 ns period
    always #4 aclk = ~aclk;

    isrc_top u_isrc_top
    (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .src20_req, .src21_req,
        .cpu_req, .cpu_level, .dma_req, .dma_chan
    );

    isrc_sink u_isrc_sink
    (
        .aclk, .aresetn, .cpu_req, .cpu_level, .dma_req, .dma_chan,
        .evt_r(evt), .evt_word_r(evt_word)
    );

    // One counted comparison
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Verdict and end of run
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Write a word; each handshake judged at the edge that takes it
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic       b_hit;
        logic [1:0] resp;
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= strb_v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
            b_hit = s_axi_bvalid;
            resp  = s_axi_bresp;
        end
        while (!b_hit);
        s_axi_bready <= 1'b0;
        chk("bresp", 32'(er), 32'(resp));
    endtask

    // Read a word; data is only meaningful on an OKAY answer
    task automatic rd(input logic [3:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        logic        r_hit;
        logic [31:0] data;
        logic [1:0]  resp;
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
            r_hit = s_axi_rvalid;
            data  = s_axi_rdata;
            resp  = s_axi_rresp;
        end
        while (!r_hit);
        s_axi_rready <= 1'b0;
        chk("rresp", 32'(er), 32'(resp));
        if (er === isrc_pkg::RESP_OKAY)
            chk("rdata", ed, data);
    endtask

    // Raise one request pin for four cycles, then let it settle
    task automatic pulse(input int s);
        @(posedge aclk);
        if (s == 0)
            src20_req <= 1'b1;
        else
            src21_req <= 1'b1;
        repeat (4) @(posedge aclk);
        src20_req <= 1'b0;
        src21_req <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask

    // Every far-side event must match the oldest expected one
    always @(posedge aclk)
        if (evt === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk("spurious event", 32'h100, 32'(evt_word));
            else
                chk("event", 32'(exp_q.pop_front()), 32'(evt_word));
        end

    // Main sequence
    initial
    begin
        logic [7:0] b;
        void'($urandom(1247));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(isrc_pkg::CFG_OFS, 32'h0, isrc_pkg::RESP_OKAY);
        rd(isrc_pkg::STAT_OFS, 32'h0, isrc_pkg::RESP_OKAY);
        wr(4'h8, 32'h3333, isrc_pkg::RESP_SLVERR);
        rd(4'hc, 32'h0, isrc_pkg::RESP_SLVERR);
        wr(isrc_pkg::STAT_OFS, 32'hffff, isrc_pkg::RESP_OKAY);
        rd(isrc_pkg::CFG_OFS, 32'h0, isrc_pkg::RESP_OKAY);
        // Every source, trigger kind and code, rising-edge sensitivity
        for (int s = 0; s < 2; s++)
            for (int k = 0; k < 16; k++)
            begin
                b = {2'b00, isrc_pkg::SENSE_RISE, k[3], k[2:0]};
                wr(isrc_pkg::CFG_OFS, 32'(b) << (8 * s),
                   isrc_pkg::RESP_OKAY);
                rd(isrc_pkg::CFG_OFS, 32'(b) << (8 * s),
                   isrc_pkg::RESP_OKAY);
                if (k[3] || k[2:0] != 3'h0)
                    exp_q.push_back({3'h0, k[3], s[0], k[2:0]});
                pulse(s);
                // Seen flag follows a routed edge, then a read clears it
                rd(isrc_pkg::STAT_OFS, (k[3] || k[2:0] != 3'h0) ?
                   32'h4 << s : 32'h0, isrc_pkg::RESP_OKAY);
                rd(isrc_pkg::STAT_OFS, 32'h0, isrc_pkg::RESP_OKAY);
            end
        // Prohibited sensitivity codes read back but detect nothing
        repeat (4)
        begin
            b = {2'b00, 2'($urandom % 3), 1'b0, 3'($urandom % 7 + 1)};
            wr(isrc_pkg::CFG_OFS, 32'(b), isrc_pkg::RESP_OKAY);
            rd(isrc_pkg::CFG_OFS, 32'(b), isrc_pkg::RESP_OKAY);
            pulse(0);
            rd(isrc_pkg::STAT_OFS, 32'h0, isrc_pkg::RESP_OKAY);
        end
        // Byte strobes: only the src21 byte may change
        strb_v = 4'h2;
        wr(isrc_pkg::CFG_OFS, 32'h3f3f, isrc_pkg::RESP_OKAY);
        rd(isrc_pkg::CFG_OFS, {16'h0000, 8'h3f, b}, isrc_pkg::RESP_OKAY);
        strb_v = 4'h3;
        // Reset in mid-run clears the configuration again
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(isrc_pkg::CFG_OFS, 32'h0, isrc_pkg::RESP_OKAY);
        chk("pending events", 32'h0, 32'(exp_q.size()));
        end_sim();
    end

    // Watchdog; the sequence needs under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge aclk);
        error_cnt++;
        end_sim();
    end
endmodule // tb
